/* File: logic/rps_top.sv */
// remappable pin select crossbar: input/output maps, lock sequence, shadow check
`timescale 1ns/1ps
`default_nettype none
// the port widths below need the constants even when this file is read on its own
`include "rps_defs.svh"
module rps_top
	import rps_pkg::*;
(
	input  wire logic                     I_MCLK,
	input  wire logic                     I_RST_N,
	input  wire logic                     I_MAP_WR,
	input  wire logic [4:0]               I_MAP_ADDR,
	input  wire logic [`RPS_SEL_W-1:0]    I_MAP_WDATA,
	input  wire logic                     I_OSC_WR,
	input  wire logic [7:0]               I_OSC_WDATA,
	input  wire logic [7:0]               I_OSC_CONFIG_WORD,
	input  wire logic [`RPS_NUM_PINS-1:0] I_PIN_IN,
	input  wire logic                     I_UART_TX_OUT,
	input  wire logic                     I_UART_RTS_OUT,
	input  wire logic                     I_SPI_DATA_OUT,
	input  wire logic                     I_SPI_CLK_OUT,
	input  wire logic                     I_SPI_SELECT_OUT,
	input  wire logic                     I_COMPARE_OUT_A,
	input  wire logic                     I_COMPARE_OUT_B,
	output logic                          O_EXT_IRQ_A,
	output logic                          O_EXT_IRQ_B,
	output logic                          O_TIMER_B_EXT_CLK,
	output logic                          O_TIMER_C_EXT_CLK,
	output logic                          O_CAPTURE_CH_A,
	output logic                          O_CAPTURE_CH_B,
	output logic                          O_CAPTURE_CH_G,
	output logic                          O_CAPTURE_CH_H,
	output logic                          O_COMPARE_FAULT_A,
	output logic                          O_UART_RX_IN,
	output logic                          O_UART_CTS_IN,
	output logic                          O_SPI_DATA_IN,
	output logic                          O_SPI_CLK_IN,
	output logic                          O_SPI_SELECT_IN,
	output logic [`RPS_NUM_PINS-1:0]      O_PIN_OUT,
	output logic [`RPS_NUM_PINS-1:0]      O_PIN_SEL,
	output logic                          O_MAP_LOCK,
	output logic                          O_ONE_WAY,
	output logic [`RPS_NUM_INS*5-1:0]     O_IN_MAP,
	output logic [`RPS_NUM_PINS*5-1:0]    O_OUT_MAP,
	output logic                          O_CFG_MISMATCH_RST
);

	// reset image: inputs point at the tie-low code, outputs at null
	localparam rps_state_t ST_RST = '{
		in_map:        {`RPS_NUM_INS{`RPS_IN_SEL_RST}},
		out_map:       {`RPS_NUM_PINS{`RPS_OUT_SEL_RST}},
		in_shadow:     {`RPS_NUM_INS{`RPS_IN_SEL_RST}},
		out_shadow:    {`RPS_NUM_PINS{`RPS_OUT_SEL_RST}},
		map_lock:      1'b0,
		lock_set_once: 1'b0,
		one_way:       1'b1,
		strap_done:    1'b0,
		seq:           RPS_SEQ_IDLE,
		sync1:         '0,
		sync2:         '0,
		sync3:         '0,
		pin_filt:      '0,
		periph_in:     '0,
		pin_out:       '0,
		pin_sel:       '0,
		mismatch:      1'b0
	};

	rps_state_t st_q;
	rps_state_t st_d;

	logic       map_wr_ok;
	logic       is_out_addr;
	logic [3:0] field_idx;
	logic [4:0] code;
	logic [4:0] isel;

	// field index within the addressed half of the map
	assign is_out_addr = I_MAP_ADDR[4];
	assign field_idx   = I_MAP_ADDR[3:0];
	// a write while locked is accepted at the port but dropped here
	assign map_wr_ok   = I_MAP_WR && !st_q.map_lock;

	// next-state logic for the whole block
	always_comb begin
		st_d = st_q;

		// strap capture one cycle after reset release, never during reset
		if (!st_q.strap_done) begin
			st_d.one_way    = I_OSC_CONFIG_WORD[`RPS_ONE_WAY_BIT];
			st_d.strap_done = 1'b1;
		end

		// map writes: live and shadow updated together, so only upsets differ
		if (map_wr_ok) begin
			if (is_out_addr) begin
				st_d.out_map[field_idx]    = I_MAP_WDATA;
				st_d.out_shadow[field_idx] = I_MAP_WDATA;
			end else if (field_idx < 4'(`RPS_NUM_INS)) begin
				st_d.in_map[field_idx]    = I_MAP_WDATA;
				st_d.in_shadow[field_idx] = I_MAP_WDATA;
			end
		end

		// unlock sequence on writes to the control low byte
		if (I_OSC_WR) begin
			case (st_q.seq)
				RPS_SEQ_IDLE: begin
					if (I_OSC_WDATA == `RPS_UNLOCK_KEY1)
						st_d.seq = RPS_SEQ_KEY1;
				end
				RPS_SEQ_KEY1: begin
					if (I_OSC_WDATA == `RPS_UNLOCK_KEY2)
						st_d.seq = RPS_SEQ_ARMED;
					else if (I_OSC_WDATA == `RPS_UNLOCK_KEY1)
						st_d.seq = RPS_SEQ_KEY1;
					else
						st_d.seq = RPS_SEQ_IDLE;
				end
				RPS_SEQ_ARMED: begin
					// the very next write decides the lock, then the key is spent
					st_d.seq = RPS_SEQ_IDLE;
					if (I_OSC_WDATA[`RPS_LOCK_BIT]) begin
						st_d.map_lock      = 1'b1;
						st_d.lock_set_once = 1'b1;
					end else if (!(st_q.one_way && st_q.lock_set_once)) begin
						st_d.map_lock = 1'b0;
					end
				end
				default: begin
					st_d.seq = RPS_SEQ_IDLE;
				end
			endcase
		end
		// no timer touches map_lock, so it stays put between sessions

		// pin inputs: three stages, a change counts once stage 2 and 3 agree
		st_d.sync1 = I_PIN_IN;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = st_q.sync2;
		for (int p = 0; p < `RPS_NUM_PINS; p++) begin
			if (st_q.sync2[p] == st_q.sync3[p])
				st_d.pin_filt[p] = st_q.sync3[p];
		end

		// input crossbar: codes past the last pin feed a low level
		for (int i = 0; i < `RPS_NUM_INS; i++) begin
			isel = st_q.in_map[i];
			if (isel < 5'(`RPS_NUM_PINS))
				st_d.periph_in[i] = st_q.pin_filt[isel[3:0]];
			else
				st_d.periph_in[i] = 1'b0;
		end

		// output crossbar: per pin, unknown codes behave like null
		for (int p = 0; p < `RPS_NUM_PINS; p++) begin
			code = st_q.out_map[p];
			st_d.pin_sel[p] = 1'b1;
			case (code)
				`RPS_OUT_UART_TX:  st_d.pin_out[p] = I_UART_TX_OUT;
				`RPS_OUT_UART_RTS: st_d.pin_out[p] = I_UART_RTS_OUT;
				`RPS_OUT_SPI_DO:   st_d.pin_out[p] = I_SPI_DATA_OUT;
				`RPS_OUT_SPI_CLK:  st_d.pin_out[p] = I_SPI_CLK_OUT;
				`RPS_OUT_SPI_SEL:  st_d.pin_out[p] = I_SPI_SELECT_OUT;
				`RPS_OUT_CMP_A:    st_d.pin_out[p] = I_COMPARE_OUT_A;
				`RPS_OUT_CMP_B:    st_d.pin_out[p] = I_COMPARE_OUT_B;
				default: begin
					// null code hands the pin back to the port
					st_d.pin_out[p] = 1'b0;
					st_d.pin_sel[p] = 1'b0;
				end
			endcase
		end

		// continuous shadow check; sticky until the reset it requests arrives
		if ((st_q.in_map != st_q.in_shadow) || (st_q.out_map != st_q.out_shadow))
			st_d.mismatch = 1'b1;
	end

	// single state register
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// peripheral inputs, one per remappable function
	assign O_EXT_IRQ_A        = st_q.periph_in[RPS_IN_IRQ_A];
	assign O_EXT_IRQ_B        = st_q.periph_in[RPS_IN_IRQ_B];
	assign O_TIMER_B_EXT_CLK  = st_q.periph_in[RPS_IN_TMR_B];
	assign O_TIMER_C_EXT_CLK  = st_q.periph_in[RPS_IN_TMR_C];
	assign O_CAPTURE_CH_A     = st_q.periph_in[RPS_IN_CAP_A];
	assign O_CAPTURE_CH_B     = st_q.periph_in[RPS_IN_CAP_B];
	assign O_CAPTURE_CH_G     = st_q.periph_in[RPS_IN_CAP_G];
	assign O_CAPTURE_CH_H     = st_q.periph_in[RPS_IN_CAP_H];
	assign O_COMPARE_FAULT_A  = st_q.periph_in[RPS_IN_FAULT_A];
	assign O_UART_RX_IN       = st_q.periph_in[RPS_IN_URX];
	assign O_UART_CTS_IN      = st_q.periph_in[RPS_IN_UCTS];
	assign O_SPI_DATA_IN      = st_q.periph_in[RPS_IN_SPI_DI];
	assign O_SPI_CLK_IN       = st_q.periph_in[RPS_IN_SPI_CK];
	assign O_SPI_SELECT_IN    = st_q.periph_in[RPS_IN_SPI_SS];

	// pin side and status, all straight from the state register
	assign O_PIN_OUT          = st_q.pin_out;
	assign O_PIN_SEL          = st_q.pin_sel;
	assign O_MAP_LOCK         = st_q.map_lock;
	assign O_ONE_WAY          = st_q.one_way;
	assign O_IN_MAP           = st_q.in_map;
	assign O_OUT_MAP          = st_q.out_map;
	assign O_CFG_MISMATCH_RST = st_q.mismatch;

endmodule : rps_top
`default_nettype wire

/* File: pkg/rps_defs.svh */
// constants for the remappable pin select crossbar
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

`define RPS_NUM_PINS      16
`define RPS_NUM_INS       14
`define RPS_SEL_W         5
// register index space: input fields from 0, pin output fields from 16
`define RPS_ADDR_OUT_BASE 5'h10
// reset values of the selector fields
`define RPS_IN_SEL_RST    5'h1f
`define RPS_OUT_SEL_RST   5'h00
// oscillator control low byte: unlock keys and lock bit position
`define RPS_UNLOCK_KEY1   8'h46
`define RPS_UNLOCK_KEY2   8'h57
`define RPS_LOCK_BIT      6
// oscillator configuration word: one-way bit position
`define RPS_ONE_WAY_BIT   5
// output selector codes
`define RPS_OUT_NULL      5'h00
`define RPS_OUT_UART_TX   5'h03
`define RPS_OUT_UART_RTS  5'h04
`define RPS_OUT_SPI_DO    5'h07
`define RPS_OUT_SPI_CLK   5'h08
`define RPS_OUT_SPI_SEL   5'h09
`define RPS_OUT_CMP_A     5'h12
`define RPS_OUT_CMP_B     5'h13

`endif

/* File: pkg/rps_pkg.sv */
// types for the remappable pin select crossbar
`default_nettype none
package rps_pkg;
	`include "rps_defs.svh"

	// peripheral input order in the input map
	typedef enum logic [3:0] {
		RPS_IN_IRQ_A   = 4'h0,
		RPS_IN_IRQ_B   = 4'h1,
		RPS_IN_TMR_B   = 4'h2,
		RPS_IN_TMR_C   = 4'h3,
		RPS_IN_CAP_A   = 4'h4,
		RPS_IN_CAP_B   = 4'h5,
		RPS_IN_CAP_G   = 4'h6,
		RPS_IN_CAP_H   = 4'h7,
		RPS_IN_FAULT_A = 4'h8,
		RPS_IN_URX     = 4'h9,
		RPS_IN_UCTS    = 4'ha,
		RPS_IN_SPI_DI  = 4'hb,
		RPS_IN_SPI_CK  = 4'hc,
		RPS_IN_SPI_SS  = 4'hd
	} rps_in_idx_t;

	// unlock sequence states
	typedef enum logic [2:0] {
		RPS_SEQ_IDLE  = 3'b001,
		RPS_SEQ_KEY1  = 3'b010,
		RPS_SEQ_ARMED = 3'b100
	} rps_seq_t;

	typedef logic [`RPS_NUM_INS-1:0][`RPS_SEL_W-1:0]  rps_in_map_t;
	typedef logic [`RPS_NUM_PINS-1:0][`RPS_SEL_W-1:0] rps_out_map_t;

	// whole state of the crossbar
	typedef struct packed {
		rps_in_map_t              in_map;
		rps_out_map_t             out_map;
		rps_in_map_t              in_shadow;
		rps_out_map_t             out_shadow;
		logic                     map_lock;
		logic                     lock_set_once;
		logic                     one_way;
		logic                     strap_done;
		rps_seq_t                 seq;
		logic [`RPS_NUM_PINS-1:0] sync1;
		logic [`RPS_NUM_PINS-1:0] sync2;
		logic [`RPS_NUM_PINS-1:0] sync3;
		logic [`RPS_NUM_PINS-1:0] pin_filt;
		logic [`RPS_NUM_INS-1:0]  periph_in;
		logic [`RPS_NUM_PINS-1:0] pin_out;
		logic [`RPS_NUM_PINS-1:0] pin_sel;
		logic                     mismatch;
	} rps_state_t;
endpackage : rps_pkg
`default_nettype wire

/* File: tb/rps_asserts.sv */
// port-level assertions for the remappable pin select crossbar
`timescale 1ns/1ps
`default_nettype none
module rps_asserts (
	input wire logic        I_MCLK,
	input wire logic        I_RST_N,
	input wire logic        I_MAP_WR,
	input wire logic [4:0]  I_MAP_ADDR,
	input wire logic [4:0]  I_MAP_WDATA,
	input wire logic        I_OSC_WR,
	input wire logic [7:0]  I_OSC_WDATA,
	input wire logic        I_UART_TX_OUT,
	input wire logic        I_COMPARE_OUT_A,
	input wire logic        O_EXT_IRQ_A,
	input wire logic [15:0] O_PIN_OUT,
	input wire logic [15:0] O_PIN_SEL,
	input wire logic        O_MAP_LOCK,
	input wire logic        O_ONE_WAY,
	input wire logic [69:0] O_IN_MAP,
	input wire logic [79:0] O_OUT_MAP,
	input wire logic        O_CFG_MISMATCH_RST
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	// level that pin 0 should carry for a code; only the codes the bench puts there
	// sources come in as arguments so that $past samples them along with the code
	function automatic logic src0(input logic [4:0] c, input logic tx, input logic cmp_a);
		return (c == 5'h03) ? tx : (c == 5'h12) ? cmp_a : 1'b0;
	endfunction : src0
	// unlock keys as separate steps so a gap or wrong byte breaks the match
	sequence s_key1; I_OSC_WR && I_OSC_WDATA == 8'h46; endsequence
	sequence s_key2; I_OSC_WR && I_OSC_WDATA == 8'h57; endsequence
	property p_lock_set;
		s_key1 ##1 s_key2 ##1 (I_OSC_WR && I_OSC_WDATA[6]) |=> O_MAP_LOCK;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not set by key bytes");
	property p_wr_out;
		!O_MAP_LOCK && I_MAP_WR && I_MAP_ADDR[4] |=>
			5'(O_OUT_MAP >> (5 * $past(I_MAP_ADDR[3:0]))) == $past(I_MAP_WDATA)
			&& $stable(O_IN_MAP);
	endproperty
	a_wr_out: assert property (p_wr_out) else $error("pin field write lost");
	property p_wr_in;
		!O_MAP_LOCK && I_MAP_WR && I_MAP_ADDR < 5'd14 |=>
			5'(O_IN_MAP >> (5 * $past(I_MAP_ADDR))) == $past(I_MAP_WDATA)
			&& $stable(O_OUT_MAP);
	endproperty
	a_wr_in: assert property (p_wr_in) else $error("input field write lost");
	property p_locked; O_MAP_LOCK && I_MAP_WR |=> $stable(O_IN_MAP) && $stable(O_OUT_MAP); endproperty
	a_locked: assert property (p_locked) else $error("map changed while locked");
	property p_hold; !I_OSC_WR |=> $stable(O_MAP_LOCK); endproperty
	a_hold: assert property (p_hold) else $error("lock moved without a write");
	property p_one_way; O_ONE_WAY && O_MAP_LOCK |=> O_MAP_LOCK; endproperty
	a_one_way: assert property (p_one_way) else $error("lock cleared in one-way mode");
	property p_route;
		1 |=> O_PIN_OUT[0] == $past(src0(O_OUT_MAP[4:0], I_UART_TX_OUT, I_COMPARE_OUT_A))
			&& O_PIN_SEL[0] == $past(O_OUT_MAP[4:0] inside
				{5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13});
	endproperty
	a_route: assert property (p_route) else $error("pin 0 routing wrong");
	property p_in_null; O_IN_MAP[4] [*3] |-> !O_EXT_IRQ_A; endproperty
	a_in_null: assert property (p_in_null) else $error("unimplemented pin not low");
	property p_no_mismatch; !O_CFG_MISMATCH_RST; endproperty
	a_no_mismatch: assert property (p_no_mismatch) else $error("shadow mismatch raised");
endmodule : rps_asserts
bind rps_top rps_asserts chk_u (.I_MCLK, .I_RST_N, .I_MAP_WR, .I_MAP_ADDR, .I_MAP_WDATA,
	.I_OSC_WR, .I_OSC_WDATA, .I_UART_TX_OUT, .I_COMPARE_OUT_A, .O_EXT_IRQ_A, .O_PIN_OUT,
	.O_PIN_SEL, .O_MAP_LOCK, .O_ONE_WAY, .O_IN_MAP, .O_OUT_MAP, .O_CFG_MISMATCH_RST);
`default_nettype wire

/* File: tb/rps_periph_model.sv */
// behavioural model of the peripherals feeding the remappable outputs
`timescale 1ns/1ps
`default_nettype none
module rps_periph_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [6:0] i_pat,
	output logic      [6:0] o_out
);
	// order: tx, rts, data, clock, select, compare a, compare b; same clock as the crossbar
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out <= 7'h00;
		end else begin
			o_out <= i_pat;
		end
	end
endmodule : rps_periph_model
`default_nettype wire

/* File: tb/rps_top_test.sv */
// self-checking bench for the remappable pin select crossbar
`timescale 1ns/1ps
`default_nettype none
module rps_top_test;
	logic        clk, rst_n, map_wr, osc_wr, lock, one_way, mm;
	logic [4:0]  map_addr, map_wdata;
	logic [7:0]  osc_wdata, cfg;
	logic [15:0] pin_in, pin_out, pin_sel;
	logic [6:0]  pat, po;
	logic [13:0] periph;
	logic [69:0] in_map;
	logic [79:0] out_map;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [4:0]  codes [7] = '{5'h03, 5'h12, 5'h13, 5'h04, 5'h07, 5'h08, 5'h09};
	logic [6:0]  pats [2] = '{7'h55, 7'h2a};

	rps_periph_model model_u (.i_clk(clk), .i_rst_n(rst_n), .i_pat(pat), .o_out(po));
	rps_top dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_MAP_WR(map_wr), .I_MAP_ADDR(map_addr),
		.I_MAP_WDATA(map_wdata), .I_OSC_WR(osc_wr), .I_OSC_WDATA(osc_wdata),
		.I_OSC_CONFIG_WORD(cfg), .I_PIN_IN(pin_in), .I_UART_TX_OUT(po[0]),
		.I_UART_RTS_OUT(po[1]), .I_SPI_DATA_OUT(po[2]), .I_SPI_CLK_OUT(po[3]),
		.I_SPI_SELECT_OUT(po[4]), .I_COMPARE_OUT_A(po[5]), .I_COMPARE_OUT_B(po[6]),
		.O_EXT_IRQ_A(periph[0]), .O_EXT_IRQ_B(periph[1]), .O_TIMER_B_EXT_CLK(periph[2]),
		.O_TIMER_C_EXT_CLK(periph[3]), .O_CAPTURE_CH_A(periph[4]), .O_CAPTURE_CH_B(periph[5]),
		.O_CAPTURE_CH_G(periph[6]), .O_CAPTURE_CH_H(periph[7]), .O_COMPARE_FAULT_A(periph[8]),
		.O_UART_RX_IN(periph[9]), .O_UART_CTS_IN(periph[10]), .O_SPI_DATA_IN(periph[11]),
		.O_SPI_CLK_IN(periph[12]), .O_SPI_SELECT_IN(periph[13]), .O_PIN_OUT(pin_out),
		.O_PIN_SEL(pin_sel), .O_MAP_LOCK(lock), .O_ONE_WAY(one_way), .O_IN_MAP(in_map),
		.O_OUT_MAP(out_map), .O_CFG_MISMATCH_RST(mm));

	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// inputs always move 1 ns after the edge so the design never races the bench
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// idle cycle after each write keeps the strobe from being set twice in one step
	task automatic map_w(input logic [4:0] a, input logic [4:0] d);
		map_addr = a;
		map_wdata = d;
		map_wr = 1'b1;
		tick(1);
		map_wr = 1'b0;
		tick(1);
	endtask : map_w
	task automatic osc_seq(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
		osc_wr = 1'b1;
		osc_wdata = b1;
		tick(1);
		osc_wdata = b2;
		tick(1);
		osc_wdata = b3;
		tick(1);
		osc_wr = 1'b0;
		tick(1);
	endtask : osc_seq
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	task automatic do_reset(input logic [7:0] c);
		cfg = c;
		rst_n = 1'b0;
		tick(6);
		rst_n = 1'b1;
		tick(1);
	endtask : do_reset

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard: a run this long counts as a failure
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	initial begin
		{map_wr, osc_wr, map_addr, map_wdata, osc_wdata, pin_in, pat} = '0;
		do_reset(8'h00);
		check(in_map, {14{5'h1f}});
		check(out_map, 80'h0);
		check(one_way, 1'b0);
		// every output code on pins 0..6, two complementary patterns
		for (int i = 0; i < 7; i++) begin
			map_w(5'h10 + 5'(i), codes[i]);
		end
		check(out_map, {45'h0, 5'h09, 5'h08, 5'h07, 5'h04, 5'h13, 5'h12, 5'h03});
		foreach (pats[k]) begin
			pat = pats[k];
			tick(3);
			check(pin_out, {9'h0, pat[4:1], pat[6:5], pat[0]});
			check(pin_sel, 16'h007f);
		end
		// pins stay inputs on the port side; irq a from pin 5, select from 15, cts from none
		map_w(5'h00, 5'h05);
		map_w(5'h0d, 5'h0f);
		map_w(5'h0a, 5'h10);
		map_w(5'h0e, 5'h01);
		// port direction bits of these pins are taken as left at input
		pin_in = 16'hffff;
		tick(6);
		check(periph, 14'h2001);
		check(in_map, {5'h0f, {2{5'h1f}}, 5'h10, {9{5'h1f}}, 5'h05});
		osc_seq(8'h46, 8'h57, 8'h40);
		check(lock, 1'b1);
		map_w(5'h10, 5'h00);
		tick(3);
		check(pin_sel, 16'h007f);
		osc_seq(8'h46, 8'h12, 8'h00);
		check(lock, 1'b1);
		osc_seq(8'h46, 8'h57, 8'h00);
		check(lock, 1'b0);
		map_w(5'h10, 5'h00);
		tick(3);
		check(pin_sel, 16'h007e);
		osc_seq(8'h46, 8'h57, 8'h40);
		osc_seq(8'h46, 8'h57, 8'h00);
		check(lock, 1'b0);
		// one-way mode: a second session must not open
		do_reset(8'h20);
		check(one_way, 1'b1);
		osc_seq(8'h46, 8'h57, 8'h40);
		osc_seq(8'h46, 8'h57, 8'h00);
		check(lock, 1'b1);
		check(mm, 1'b0);
		conclude();
	end
endmodule : rps_top_test
`default_nettype wire
